// ### lsse_exec.sv
`timescale 1ns/10ps
`default_nettype none
module lsse_exec #(
  parameter int ADDR_W = lsse_pkg::DEF_ADDR_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // instruction issue
  input wire logic issueValid,
  input wire lsse_pkg::lsse_issue_type issueCmd,
  output logic issueReady,
  // data memory read port, data one cycle after the enable
  output logic memRdEn,
  output logic [ADDR_W-1:0] memRdAddr,
  input wire logic [lsse_pkg::DATA_W-1:0] memRdData,
  // data memory write port
  output logic memWrEn,
  output logic [ADDR_W-1:0] memWrAddr,
  output logic [lsse_pkg::DATA_W-1:0] memWrData,
  // accumulator
  input wire logic [lsse_pkg::DATA_W-1:0] accIn,
  output logic accWrEn,
  output logic [lsse_pkg::DATA_W-1:0] accWrData,
  // status flags
  output logic flagsWrEn,
  output lsse_pkg::lsse_flags_type flagsWr,
  // sequencing
  output logic skipNext,
  output logic dummyCycle,
  output logic instrDone
);
  import lsse_pkg::*;

  if (ADDR_W < 1 || ADDR_W > DEF_ADDR_W) begin : g_bad_addr_w
    $error("lsse_exec: ADDR_W out of range");
  end

  function automatic logic cmd_known(input logic [3:0] c);
    cmd_known = (c <= CMD_MOVE_ACC_SKZ);
  endfunction : cmd_known

  function automatic logic [DATA_W-1:0] bit_mask(
    input logic [BIT_SEL_W-1:0] s
  );
    bit_mask = BYTE_ONE << s;
  endfunction : bit_mask

  lsse_state_type state_ff;
  lsse_state_type nxt_state;
  logic [3:0] cmd_ff;
  logic [BIT_SEL_W-1:0] bitSel_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic memRdEn_ff;
  logic memWrEn_ff;
  logic [ADDR_W-1:0] memWrAddr_ff;
  logic [DATA_W-1:0] memWrData_ff;
  logic accWrEn_ff;
  logic [DATA_W-1:0] accWrData_ff;
  logic flagsWrEn_ff;
  lsse_flags_type flagsWr_ff;
  logic skipNext_ff;
  logic dummyCycle_ff;
  logic instrDone_ff;

  logic [DATA_W-1:0] subDiff;
  lsse_flags_type subFlags;

  logic [DATA_W-1:0] decVal;
  logic [DATA_W-1:0] incVal;
  logic [DATA_W-1:0] swapVal;
  logic selBit;
  logic nxt_memWrEn;
  logic [DATA_W-1:0] nxt_memWrData;
  logic nxt_accWrEn;
  logic [DATA_W-1:0] nxt_accWrData;
  logic nxt_flagsWrEn;
  logic nxt_skip;
  logic issueTake;

  lsse_sub_unit u_sub (
    .minuend(accIn),
    .subtrahend(memRdData),
    .diff(subDiff),
    .flags(subFlags)
  );

  // unknown codes are held off rather than taken and dropped later
  assign issueReady = (state_ff == ST_IDLE) && cmd_known(issueCmd.cmd);
  assign issueTake = issueValid && issueReady;

  always_comb begin
    decVal = memRdData - BYTE_ONE;
    incVal = memRdData + BYTE_ONE;
    swapVal = {memRdData[3:0], memRdData[7:4]};
    selBit = |(memRdData & bit_mask(bitSel_ff));
  end

  // result steering for the execute cycle
  always_comb begin
    nxt_memWrEn = 1'b0;
    nxt_memWrData = memRdData;
    nxt_accWrEn = 1'b0;
    nxt_accWrData = memRdData;
    nxt_flagsWrEn = 1'b0; // [RULE_19]
    nxt_skip = 1'b0;
    unique case (cmd_ff)
      CMD_DEC_SKZ: begin
        nxt_memWrEn = 1'b1;
        nxt_memWrData = decVal;
        nxt_skip = (decVal == BYTE_ZERO); // [RULE_01]
      end
      CMD_DEC_ACC_SKZ: begin
        nxt_accWrEn = 1'b1;
        nxt_accWrData = decVal;
        nxt_skip = (decVal == BYTE_ZERO); // [RULE_03]
      end
      CMD_SET_BYTE: begin
        nxt_memWrEn = 1'b1;
        nxt_memWrData = BYTE_ALL_ONES; // [RULE_04]
      end
      CMD_SET_BIT: begin
        nxt_memWrEn = 1'b1;
        nxt_memWrData = memRdData | bit_mask(bitSel_ff); // [RULE_05]
      end
      CMD_INC_SKZ: begin
        nxt_memWrEn = 1'b1;
        nxt_memWrData = incVal;
        nxt_skip = (incVal == BYTE_ZERO); // [RULE_06]
      end
      CMD_INC_ACC_SKZ: begin
        nxt_accWrEn = 1'b1;
        nxt_accWrData = incVal;
        nxt_skip = (incVal == BYTE_ZERO); // [RULE_07]
      end
      CMD_SKNZ_BIT: begin
        nxt_skip = selBit; // [RULE_08]
      end
      CMD_SKNZ_BYTE: begin
        // same byte goes back, as a read-modify-write with no change
        nxt_memWrEn = 1'b1;
        nxt_skip = (memRdData != BYTE_ZERO); // [RULE_09]
      end
      CMD_SUB_ACC: begin
        nxt_accWrEn = 1'b1;
        nxt_accWrData = subDiff; // [RULE_10]
        nxt_flagsWrEn = 1'b1; // [RULE_13]
      end
      CMD_SUB_MEM: begin
        nxt_memWrEn = 1'b1;
        nxt_memWrData = subDiff; // [RULE_11]
        nxt_flagsWrEn = 1'b1; // [RULE_13]
      end
      CMD_SWAP: begin
        nxt_memWrEn = 1'b1;
        nxt_memWrData = swapVal; // [RULE_14]
      end
      CMD_SWAP_ACC: begin
        nxt_accWrEn = 1'b1;
        nxt_accWrData = swapVal; // [RULE_15]
      end
      CMD_SKZ_BYTE: begin
        nxt_memWrEn = 1'b1;
        nxt_skip = (memRdData == BYTE_ZERO); // [RULE_16]
      end
      CMD_MOVE_ACC_SKZ: begin
        nxt_accWrEn = 1'b1;
        nxt_skip = (memRdData == BYTE_ZERO); // [RULE_17]
      end
      default: begin
        nxt_skip = 1'b0;
      end
    endcase
  end

  // sequencer
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (issueTake) begin
          nxt_state = ST_READ;
        end
      end
      ST_READ: begin
        nxt_state = ST_EXEC;
      end
      ST_EXEC: begin
        if (nxt_skip) begin
          nxt_state = ST_DUMMY; // [RULE_02]
        end else begin
          nxt_state = ST_IDLE; // [RULE_18]
        end
      end
      ST_DUMMY: begin
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // issue capture
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cmd_ff <= 4'h0;
      bitSel_ff <= '0;
      addr_ff <= '0;
    end else if (issueTake) begin
      cmd_ff <= issueCmd.cmd;
      bitSel_ff <= issueCmd.bitSel;
      addr_ff <= issueCmd.addr[ADDR_W-1:0];
    end
  end

  // memory read request
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      memRdEn_ff <= 1'b0;
    end else begin
      memRdEn_ff <= issueTake;
    end
  end

  // memory write-back
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      memWrEn_ff <= 1'b0;
      memWrAddr_ff <= '0;
      memWrData_ff <= RESET_BYTE;
    end else begin
      memWrEn_ff <= (state_ff == ST_EXEC) && nxt_memWrEn;
      if (state_ff == ST_EXEC) begin
        memWrAddr_ff <= addr_ff;
        memWrData_ff <= nxt_memWrData;
      end
    end
  end

  // accumulator write
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      accWrEn_ff <= 1'b0;
      accWrData_ff <= RESET_BYTE;
    end else begin
      accWrEn_ff <= (state_ff == ST_EXEC) && nxt_accWrEn;
      if (state_ff == ST_EXEC) begin
        accWrData_ff <= nxt_accWrData;
      end
    end
  end

  // flag write, subtract forms only
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flagsWrEn_ff <= 1'b0;
      flagsWr_ff <= RESET_FLAGS;
    end else begin
      flagsWrEn_ff <= (state_ff == ST_EXEC) && nxt_flagsWrEn; // [RULE_19]
      if ((state_ff == ST_EXEC) && nxt_flagsWrEn) begin
        flagsWr_ff <= subFlags; // [RULE_12]
      end
    end
  end

  // skip and dummy cycle markers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      skipNext_ff <= 1'b0;
      dummyCycle_ff <= 1'b0;
      instrDone_ff <= 1'b0;
    end else begin
      skipNext_ff <= (state_ff == ST_EXEC) && nxt_skip; // [RULE_02]
      dummyCycle_ff <= (nxt_state == ST_DUMMY); // [RULE_02]
      instrDone_ff <= (state_ff != ST_IDLE) &&
                      (nxt_state == ST_IDLE); // [RULE_18]
    end
  end

  assign memRdEn = memRdEn_ff;
  assign memRdAddr = addr_ff;
  assign memWrEn = memWrEn_ff;
  assign memWrAddr = memWrAddr_ff;
  assign memWrData = memWrData_ff;
  assign accWrEn = accWrEn_ff;
  assign accWrData = accWrData_ff;
  assign flagsWrEn = flagsWrEn_ff;
  assign flagsWr = flagsWr_ff;
  assign skipNext = skipNext_ff;
  assign dummyCycle = dummyCycle_ff;
  assign instrDone = instrDone_ff;

endmodule : lsse_exec
`default_nettype wire

// ### lsse_pkg.sv
// Functional notes
// [RULE_01] decrement-skip: byte minus one written back, skip when result zero
// [RULE_02] any taken skip makes the instruction three cycles via a dummy cycle
// [RULE_03] decrement-to-acc: byte minus one to acc, memory kept, skip if zero
// [RULE_04] byte set writes all ones, flags untouched
// [RULE_05] bit set forces chosen bit to one, other bits and flags kept
// [RULE_06] increment-skip: byte plus one written back, skip when result zero
// [RULE_07] increment-to-acc: byte plus one to acc, memory kept, skip if zero
// [RULE_08] bit test nonzero skips when chosen bit is one
// [RULE_09] byte test nonzero rewrites same byte, skips when byte not zero
// [RULE_10] subtract: acc minus byte stored in acc
// [RULE_11] memory subtract: acc minus byte stored in memory, acc kept
// [RULE_12] subtract carry cleared on negative result, set on zero or positive
// [RULE_13] subtract updates overflow, zero, aux carry, carry, signed, combined
// [RULE_14] nibble swap exchanges byte halves in place, flags untouched
// [RULE_15] swap-to-acc puts exchanged byte in acc, memory kept
// [RULE_16] byte test zero rewrites same byte, skips when byte is zero
// [RULE_17] move-to-acc copies byte to acc, skips when it is zero, no flags
// [RULE_18] skip not met: next instruction follows with no dummy cycle
// [RULE_19] skip, set, swap and test forms change no status flag at all
package lsse_pkg;

  localparam int DATA_W = 8;
  localparam int BIT_SEL_W = 3;
  localparam int DEF_ADDR_W = 11;
  localparam logic [DATA_W-1:0] BYTE_ALL_ONES = 8'hff;
  localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic [DATA_W-1:0] BYTE_ONE = 8'h01;
  localparam logic [DATA_W-1:0] RESET_BYTE = 8'h00;

  // command codes; 4'he and 4'hf are not used and are refused at issue
  typedef enum logic [3:0] {
    CMD_DEC_SKZ = 4'h0,
    CMD_DEC_ACC_SKZ = 4'h1,
    CMD_SET_BYTE = 4'h2,
    CMD_SET_BIT = 4'h3,
    CMD_INC_SKZ = 4'h4,
    CMD_INC_ACC_SKZ = 4'h5,
    CMD_SKNZ_BIT = 4'h6,
    CMD_SKNZ_BYTE = 4'h7,
    CMD_SUB_ACC = 4'h8,
    CMD_SUB_MEM = 4'h9,
    CMD_SWAP = 4'ha,
    CMD_SWAP_ACC = 4'hb,
    CMD_SKZ_BYTE = 4'hc
  } lsse_cmd_type;

  localparam logic [3:0] CMD_MOVE_ACC_SKZ = 4'hd;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_READ = 4'b0010,
    ST_EXEC = 4'b0100,
    ST_DUMMY = 4'b1000
  } lsse_state_type;

  typedef struct packed {
    logic [3:0] cmd;
    logic [BIT_SEL_W-1:0] bitSel;
    logic [DEF_ADDR_W-1:0] addr;
  } lsse_issue_type;

  typedef struct packed {
    logic overflow_flag;
    logic zero;
    logic aux_carry_flag;
    logic carry;
    logic signed_compare_flag;
    logic combined_zero_flag;
  } lsse_flags_type;

  localparam lsse_flags_type RESET_FLAGS = 6'h00;

endpackage : lsse_pkg

// ### lsse_sub_unit.sv
`timescale 1ns/10ps
`default_nettype none
module lsse_sub_unit (
  // operands
  input wire logic [lsse_pkg::DATA_W-1:0] minuend,
  input wire logic [lsse_pkg::DATA_W-1:0] subtrahend,
  // result
  output logic [lsse_pkg::DATA_W-1:0] diff,
  output lsse_pkg::lsse_flags_type flags
);
  import lsse_pkg::*;

  logic [DATA_W:0] wide;
  logic [4:0] lowNib;
  logic neg;

  always_comb begin
    wide = {1'b0, minuend} - {1'b0, subtrahend};
    lowNib = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]};
    diff = wide[DATA_W-1:0];
    flags.carry = ~wide[DATA_W]; // [RULE_12]
    flags.aux_carry_flag = ~lowNib[4]; // [RULE_13]
    flags.overflow_flag = (minuend[7] ^ subtrahend[7]) &
                          (wide[7] ^ minuend[7]); // [RULE_13]
    flags.zero = (wide[DATA_W-1:0] == BYTE_ZERO); // [RULE_13]
    neg = wide[7] ^ flags.overflow_flag;
    // signed greater-or-equal; no carry-in so the combined zero is plain zero
    flags.signed_compare_flag = ~neg; // [RULE_13]
    flags.combined_zero_flag = flags.zero; // [RULE_13]
  end

endmodule : lsse_sub_unit
`default_nettype wire

// ### lsse_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
module lsse_mem_model (
  // clock
  input wire logic clk,
  // memory ports
  input wire logic memRdEn,
  input wire logic [10:0] memRdAddr,
  output var logic [7:0] memRdData,
  input wire logic memWrEn,
  input wire logic [10:0] memWrAddr,
  input wire logic [7:0] memWrData,
  // accumulator and flags
  output var logic [7:0] accIn,
  input wire logic accWrEn,
  input wire logic [7:0] accWrData,
  input wire logic flagsWrEn,
  input wire lsse_pkg::lsse_flags_type flagsWr,
  output var lsse_pkg::lsse_flags_type flags
);
  import lsse_pkg::*;
  logic [7:0] mem [2048];
  initial begin
    memRdData = 8'h00;
    accIn = 8'h00;
    flags = RESET_FLAGS;
  end
  // read data is only good the cycle after the enable, so scramble it
  always @(posedge clk) begin
    memRdData <= memRdEn ? mem[memRdAddr] : ~memRdData;
    if (memWrEn) mem[memWrAddr] <= memWrData;
    if (accWrEn) accIn <= accWrData;
    if (flagsWrEn) flags <= flagsWr;
  end
endmodule : lsse_mem_model
`default_nettype wire

// ### lsse_exec_chk.sv
`timescale 1ns/10ps
`default_nettype none
module lsse_exec_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic issueValid,
  input wire lsse_pkg::lsse_issue_type issueCmd,
  input wire logic issueReady,
  input wire logic memRdEn,
  input wire logic [7:0] memRdData,
  input wire logic memWrEn,
  input wire logic [7:0] memWrData,
  input wire logic [7:0] accIn,
  input wire logic accWrEn,
  input wire logic [7:0] accWrData,
  input wire logic flagsWrEn,
  input wire lsse_pkg::lsse_flags_type flagsWr,
  input wire logic skipNext,
  input wire logic dummyCycle,
  input wire logic instrDone
);
  import lsse_pkg::*;
  logic [3:0] cmd_ff;
  logic [2:0] bit_ff;
  logic rdPend_ff;
  logic [7:0] rd_ff;
  logic [7:0] acc_ff;
  always_ff @(posedge clk) begin
    if (issueValid && issueReady) begin
      cmd_ff <= issueCmd.cmd;
      bit_ff <= issueCmd.bitSel;
    end
  end
  // operands as the design saw them in its execute cycle
  always_ff @(posedge clk) begin
    rdPend_ff <= rst_n && memRdEn;
    if (rdPend_ff) begin
      rd_ff <= memRdData;
      acc_ff <= accIn;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  property p_take;
    issueValid && issueReady |=> memRdEn && !issueReady;
  endproperty
  a_take: assert property (p_take)
    else $error("no read after take");
  property p_skip;
    memRdEn ##2 skipNext |-> dummyCycle && !instrDone ##1 instrDone;
  endproperty
  a_skip: assert property (p_skip)
    else $error("skip not three cycles");
  property p_noskip;
    memRdEn ##2 !skipNext |-> instrDone && !dummyCycle;
  endproperty
  a_noskip: assert property (p_noskip)
    else $error("dummy without skip");
  property p_dec;
    memWrEn && cmd_ff == 4'h0 |->
      memWrData == rd_ff - 8'h01 && skipNext == (rd_ff == 8'h01);
  endproperty
  a_dec: assert property (p_dec)
    else $error("decrement wrong");
  property p_inc;
    memWrEn && cmd_ff == 4'h4 |->
      memWrData == rd_ff + 8'h01 && skipNext == (rd_ff == 8'hff);
  endproperty
  a_inc: assert property (p_inc)
    else $error("increment wrong");
  property p_set;
    memWrEn && cmd_ff[3:1] == 3'h1 |-> memWrData ==
      (cmd_ff[0] ? rd_ff | (8'h01 << bit_ff) : 8'hff);
  endproperty
  a_set: assert property (p_set)
    else $error("set wrong");
  property p_memkeep;
    memWrEn |-> !(cmd_ff inside {4'h1, 4'h5, 4'h8, 4'hb, 4'hd});
  endproperty
  a_memkeep: assert property (p_memkeep)
    else $error("memory written by acc form");
  property p_sub;
    accWrEn && cmd_ff == 4'h8 |-> accWrData == acc_ff - rd_ff && flagsWrEn;
  endproperty
  a_sub: assert property (p_sub)
    else $error("subtract wrong");
  property p_carry;
    flagsWrEn |-> flagsWr.carry == (acc_ff >= rd_ff)
      && flagsWr.zero == (acc_ff == rd_ff);
  endproperty
  a_carry: assert property (p_carry)
    else $error("carry wrong");
  property p_flagsub;
    flagsWrEn |-> cmd_ff[3:1] == 3'h4;
  endproperty
  a_flagsub: assert property (p_flagsub)
    else $error("flags by non subtract");
  property p_swap;
    memWrEn && cmd_ff == 4'ha |-> memWrData == {rd_ff[3:0], rd_ff[7:4]};
  endproperty
  a_swap: assert property (p_swap)
    else $error("swap wrong");
endmodule : lsse_exec_chk
bind lsse_exec lsse_exec_chk u_chk (.clk(clk), .rst_n(rst_n),
  .issueValid(issueValid), .issueCmd(issueCmd), .issueReady(issueReady),
  .memRdEn(memRdEn), .memRdData(memRdData), .memWrEn(memWrEn),
  .memWrData(memWrData), .accIn(accIn), .accWrEn(accWrEn),
  .accWrData(accWrData), .flagsWrEn(flagsWrEn), .flagsWr(flagsWr),
  .skipNext(skipNext), .dummyCycle(dummyCycle), .instrDone(instrDone));
`default_nettype wire

// ### lsse_exec_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module lsse_exec_tb_top;
  import lsse_pkg::*;
  logic clk, rst_n, issueValid, issueReady, memRdEn, memWrEn, accWrEn;
  logic flagsWrEn, skipNext, dummyCycle, instrDone;
  lsse_issue_type issueCmd;
  logic [10:0] rdAddr, wrAddr;
  logic [7:0] memRdData, memWrData, accIn, accWrData;
  lsse_flags_type flagsWr, flags;
  int errTotal, checked;
  lsse_exec u_dut (.clk(clk), .rst_n(rst_n), .issueValid(issueValid),
    .issueCmd(issueCmd), .issueReady(issueReady), .memRdEn(memRdEn),
    .memRdAddr(rdAddr), .memRdData(memRdData), .memWrEn(memWrEn),
    .memWrAddr(wrAddr), .memWrData(memWrData), .accIn(accIn),
    .accWrEn(accWrEn), .accWrData(accWrData), .flagsWrEn(flagsWrEn),
    .flagsWr(flagsWr), .skipNext(skipNext), .dummyCycle(dummyCycle),
    .instrDone(instrDone));
  lsse_mem_model u_mem (.clk(clk), .memRdEn(memRdEn), .memRdAddr(rdAddr),
    .memRdData(memRdData), .memWrEn(memWrEn), .memWrAddr(wrAddr),
    .memWrData(memWrData), .accIn(accIn), .accWrEn(accWrEn),
    .accWrData(accWrData), .flagsWrEn(flagsWrEn), .flagsWr(flagsWr),
    .flags(flags));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic stop_test();
    $display("errors %0d checks %0d", errTotal, checked);
    if (errTotal == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      errTotal++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  function automatic lsse_flags_type subF(input logic [7:0] a, m);
    logic [7:0] d;
    logic ov;
    d = a - m;
    ov = (a[7] ^ m[7]) & (d[7] ^ a[7]);
    return '{ov, d == 8'h00, a[3:0] >= m[3:0], a >= m, ~(d[7] ^ ov),
      d == 8'h00};
  endfunction : subF
  // bit select is the low three command bits, the address is per command
  task automatic op(input logic [3:0] c, input logic [7:0] m, a, eM, eA,
      input logic sk);
    logic [10:0] ad;
    lsse_flags_type eF;
    logic s;
    int n;
    ad = {c, c[2:0], 4'h5};
    u_mem.mem[ad] = m;
    u_mem.accIn = a;
    eF = (c[3:1] == 3'h4) ? subF(a, m) : flags;
    issueCmd = '{c, c[2:0], ad};
    issueValid = 1'b1;
    @(posedge clk);
    #1;
    issueValid = 1'b0;
    s = 1'b0;
    n = 0;
    while (instrDone !== 1'b1 && n < 8) begin
      s = s | (skipNext === 1'b1);
      @(posedge clk);
      #1;
      n++;
    end
    s = s | (skipNext === 1'b1);
    check(8'(n), sk ? 8'h03 : 8'h02);
    check({7'h00, s}, {7'h00, sk});
    @(posedge clk);
    #1;
    check(u_mem.mem[ad], eM);
    check(accIn, eA);
    check({2'h0, flags}, {2'h0, eF});
  endtask : op
  task automatic s_dec();
    op(4'h0, 8'h01, 8'h33, 8'h00, 8'h33, 1'b1);
    op(4'h0, 8'h00, 8'h33, 8'hff, 8'h33, 1'b0);
    op(4'h1, 8'h01, 8'h77, 8'h01, 8'h00, 1'b1);
    op(4'h1, 8'h80, 8'h77, 8'h80, 8'h7f, 1'b0);
  endtask : s_dec
  task automatic s_set();
    op(4'h2, 8'h5a, 8'h00, 8'hff, 8'h00, 1'b0);
    op(4'h3, 8'h00, 8'h00, 8'h08, 8'h00, 1'b0);
    op(4'h3, 8'hf7, 8'h00, 8'hff, 8'h00, 1'b0);
  endtask : s_set
  task automatic s_inc();
    op(4'h4, 8'hff, 8'h11, 8'h00, 8'h11, 1'b1);
    op(4'h4, 8'h7f, 8'h11, 8'h80, 8'h11, 1'b0);
    op(4'h5, 8'hff, 8'h11, 8'hff, 8'h00, 1'b1);
    op(4'h5, 8'h00, 8'h11, 8'h00, 8'h01, 1'b0);
  endtask : s_inc
  task automatic s_test();
    op(4'h6, 8'h40, 8'h22, 8'h40, 8'h22, 1'b1);
    op(4'h6, 8'hbf, 8'h22, 8'hbf, 8'h22, 1'b0);
    op(4'h7, 8'h01, 8'h22, 8'h01, 8'h22, 1'b1);
    op(4'h7, 8'h00, 8'h22, 8'h00, 8'h22, 1'b0);
    op(4'hc, 8'h00, 8'h22, 8'h00, 8'h22, 1'b1);
    op(4'hc, 8'h80, 8'h22, 8'h80, 8'h22, 1'b0);
    op(4'hd, 8'h00, 8'h22, 8'h00, 8'h00, 1'b1);
    op(4'hd, 8'h3c, 8'h22, 8'h3c, 8'h3c, 1'b0);
  endtask : s_test
  task automatic s_sub();
    op(4'h8, 8'h20, 8'h10, 8'h20, 8'hf0, 1'b0);
    op(4'h8, 8'h01, 8'h80, 8'h01, 8'h7f, 1'b0);
    op(4'h9, 8'h05, 8'h05, 8'h00, 8'h05, 1'b0);
  endtask : s_sub
  task automatic s_swap();
    op(4'ha, 8'ha5, 8'h44, 8'h5a, 8'h44, 1'b0);
    op(4'hb, 8'h3c, 8'h44, 8'h3c, 8'hc3, 1'b0);
  endtask : s_swap
  // unknown codes must never be taken
  task automatic s_refuse();
    issueCmd = '{4'he, 3'h0, 11'h000};
    issueValid = 1'b1;
    repeat (3) begin
      @(posedge clk);
      #1;
      check({7'h00, issueReady | memRdEn}, 8'h00);
    end
    issueValid = 1'b0;
  endtask : s_refuse
  // reset in mid-instruction must drop it with no write-back
  task automatic s_reset();
    logic [10:0] ad;
    ad = 11'h3a5;
    u_mem.mem[ad] = 8'h01;
    issueCmd = '{4'h0, 3'h0, ad};
    issueValid = 1'b1;
    @(posedge clk);
    #1;
    issueValid = 1'b0;
    rst_n = 1'b0;
    @(posedge clk);
    #1;
    rst_n = 1'b1;
    repeat (2) begin
      check({memRdEn, memWrEn, accWrEn, flagsWrEn, skipNext, dummyCycle,
        instrDone, issueReady}, 8'h01);
      @(posedge clk);
      #1;
    end
    check(u_mem.mem[ad], 8'h01);
    op(4'h0, 8'h02, 8'h33, 8'h01, 8'h33, 1'b0);
  endtask : s_reset
  initial begin
    #20000;
    errTotal++;
    stop_test();
  end
  initial begin
    errTotal = 0;
    checked = 0;
    rst_n = 1'b0;
    issueValid = 1'b0;
    issueCmd = '0;
    repeat (8) @(posedge clk);
    #1;
    rst_n = 1'b1;
    s_dec();
    s_set();
    s_inc();
    s_test();
    s_sub();
    s_swap();
    s_reset();
    s_refuse();
    stop_test();
  end
endmodule : lsse_exec_tb_top
`default_nettype wire
